// >>> logic/ecw_pkg.sv
// Purpose: constants for the extended config window and error flags
// Assumes: one port's config space, dword registers, byte enables
// Notes: offsets are byte addresses within the config space
// Contract
// R1 - pointer bits 7:2 hold dword index
// R2 - pointer bits 11:8 hold extended index
// R3 - offset is ext, dword, 2'b00; reserved zero
// R4 - window read returns selected register
// R5 - window write updates selected register semantics
// R6 - window byte enables apply to target
// R7 - pointer at window: read zero, drop writes
// R8 - pointer at itself: window writes pointer
// R9 - management-bus window access is inert
// R10 - header capability identifier is 0x1
// R11 - version 1, lockable next pointer 0x200
// R12 - bit 0 obsolete, resets zero
// R13 - bit 4 link protocol error, write-one-clear
// R14 - bit 5 surprise down, gated by capability
// R15 - bit 12 poisoned packet received
// R16 - bit 13 flow control protocol error
// R17 - bit 14 completion timeout hardwired zero
// R18 - bit 15 completer abort reads zero
// R19 - bit 16 unexpected completion
// R20 - bit 17 receiver overflow
// R21 - bit 18 malformed packet
// R22 - bit 19 end-to-end crc error
// R23 - bit 20 unsupported request
// R24 - sticky except power-on; writing zero keeps
package ecw_pkg;
    localparam logic [11:0] OFS_POINTER = 12'h0f8;
    localparam logic [11:0] OFS_WINDOW = 12'h0fc;
    localparam logic [11:0] OFS_CAP_HDR = 12'h100;
    localparam logic [11:0] OFS_UE_FLAGS = 12'h104;
    localparam int PTR_DW_LSB = 2;
    localparam int PTR_DW_MSB = 7;
    localparam int PTR_EXT_LSB = 8;
    localparam int PTR_EXT_MSB = 11;
    localparam logic [31:0] PTR_RESET = 32'h0000_0000;
    localparam logic [31:0] PTR_WMASK = 32'h0000_0ffc;
    localparam logic [15:0] CAP_ID = 16'h0001;
    localparam logic [3:0] CAP_VER = 4'h1;
    localparam logic [11:0] NXT_PTR_RESET = 12'h200;
    localparam int NXT_LSB = 20;
    localparam logic [31:0] UE_RESET = 32'h0000_0000;
    // implemented w1c flag positions
    localparam logic [31:0] UE_IMPL = 32'h001f_3031;
    localparam int UE_OBS = 0;
    localparam int UE_DLP = 4;
    localparam int UE_SD = 5;
    localparam int UE_POIS = 12;
    localparam int UE_FCP = 13;
    localparam int UE_UEC = 16;
    localparam int UE_ROVR = 17;
    localparam int UE_MAL = 18;
    localparam int UE_ECRC = 19;
    localparam int UE_UR = 20;
endpackage

// >>> logic/ecw_regs.sv
// Purpose: indirect config window plus error header and error flags
// Assumes: one-cycle cfg access, read data registered next cycle
// Notes: port reset keeps sticky flags; power-on reset, w1c writes and capability low (bit 5) clear them
`timescale 1ns/1ps
module ecw_regs (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic por_n_i,
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic cfg_smbus_i,
    input wire logic [11:0] cfg_addr_i,
    input wire logic [3:0] cfg_be_i,
    input wire logic [31:0] cfg_wdata_i,
    output logic [31:0] cfg_rdata_o,
    output logic cfg_rvalid_o,
    input wire logic nxt_ptr_lock_i,
    input wire logic surprise_down_capable_i,
    input wire logic err_link_protocol_i,
    input wire logic err_surprise_down_i,
    input wire logic err_poisoned_i,
    input wire logic err_flow_control_i,
    input wire logic err_unexp_cpl_i,
    input wire logic err_rcv_overflow_i,
    input wire logic err_malformed_i,
    input wire logic err_ecrc_i,
    input wire logic err_unsup_req_i,
    output logic [31:0] uncorrectable_error_flags_o,
    output logic [11:0] window_target_o
);
    logic [31:0] ext_cfg_pointer_ff;
    logic [11:0] next_capability_pointer_ff;
    logic [31:0] uncorrectable_error_flags_ff;
    logic [31:0] cfg_rdata_ff;
    logic cfg_rvalid_ff;
    logic [11:0] target;
    logic win_hit;
    logic win_ok;
    logic [11:0] eff_addr;
    logic eff_wr;
    logic eff_rd;
    logic [31:0] bmask;
    logic [31:0] rd_mux;
    logic [31:0] ev;
    logic [31:0] nxt_flags;

    // byte offset named by the pointer
    assign target = {ext_cfg_pointer_ff[ecw_pkg::PTR_EXT_MSB:
        ecw_pkg::PTR_EXT_LSB], ext_cfg_pointer_ff[ecw_pkg::PTR_DW_MSB:
        ecw_pkg::PTR_DW_LSB], 2'b00}; // [R1] [R2] [R3]
    assign window_target_o = target;

    // window redirects the access; smbus and self-target make it inert
    assign win_hit = cfg_addr_i == ecw_pkg::OFS_WINDOW;
    assign win_ok = win_hit && !cfg_smbus_i
        && target != ecw_pkg::OFS_WINDOW; // [R7] [R9]
    assign eff_addr = win_hit ? target : cfg_addr_i; // [R4] [R5]
    assign eff_wr = cfg_wr_i && (!win_hit || win_ok); // [R7] [R9]
    assign eff_rd = cfg_rd_i && (!win_hit || win_ok);
    // byte enables of the window access reach the target, byte by byte
    for (genvar gi = 0; gi < 4; gi++) begin : g_bmask
        assign bmask[gi*8 +: 8] = {8{cfg_be_i[gi]}}; // [R6]
    end

    // read mux, reads have no side effects here
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (eff_addr)
            ecw_pkg::OFS_POINTER: rd_mux = ext_cfg_pointer_ff; // [R8]
            ecw_pkg::OFS_CAP_HDR: rd_mux = {next_capability_pointer_ff,
                ecw_pkg::CAP_VER, ecw_pkg::CAP_ID}; // [R10] [R11]
            ecw_pkg::OFS_UE_FLAGS: rd_mux = uncorrectable_error_flags_ff;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // registered read data, masked by byte enables
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            cfg_rdata_ff <= 32'h0000_0000;
            cfg_rvalid_ff <= 1'b0;
        end else begin
            cfg_rvalid_ff <= cfg_rd_i;
            cfg_rdata_ff <= eff_rd ? (rd_mux & bmask)
                : 32'h0000_0000; // [R4] [R6] [R7] [R9]
        end
    end
    assign cfg_rdata_o = cfg_rdata_ff;
    assign cfg_rvalid_o = cfg_rvalid_ff;

    // pointer, also reachable through the window when aimed at itself
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            ext_cfg_pointer_ff <= ecw_pkg::PTR_RESET;
        end else if (eff_wr && eff_addr == ecw_pkg::OFS_POINTER) begin
            ext_cfg_pointer_ff <= (ext_cfg_pointer_ff & ~bmask)
                | (cfg_wdata_i & bmask & ecw_pkg::PTR_WMASK); // [R3] [R8]
        end
    end

    // lockable next pointer: writes only while unlocked
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            next_capability_pointer_ff <= ecw_pkg::NXT_PTR_RESET; // [R11]
        end else if (eff_wr && eff_addr == ecw_pkg::OFS_CAP_HDR
            && !nxt_ptr_lock_i) begin
            next_capability_pointer_ff <= (next_capability_pointer_ff
                & ~bmask[31:ecw_pkg::NXT_LSB])
                | (cfg_wdata_i[31:ecw_pkg::NXT_LSB]
                & bmask[31:ecw_pkg::NXT_LSB]); // [R5] [R11]
        end
    end

    // detected events; bit 0, 14, 15 never set
    always_comb begin
        ev = 32'h0000_0000;
        ev[ecw_pkg::UE_DLP] = err_link_protocol_i; // [R13]
        ev[ecw_pkg::UE_SD] = err_surprise_down_i
            && surprise_down_capable_i; // [R14]
        ev[ecw_pkg::UE_POIS] = err_poisoned_i; // [R15]
        ev[ecw_pkg::UE_FCP] = err_flow_control_i; // [R16]
        ev[ecw_pkg::UE_UEC] = err_unexp_cpl_i; // [R19]
        ev[ecw_pkg::UE_ROVR] = err_rcv_overflow_i; // [R20]
        ev[ecw_pkg::UE_MAL] = err_malformed_i; // [R21]
        ev[ecw_pkg::UE_ECRC] = err_ecrc_i; // [R22]
        ev[ecw_pkg::UE_UR] = err_unsup_req_i; // [R23]
    end

    // w1c clear then set, so a same-cycle event is never lost
    always_comb begin
        nxt_flags = uncorrectable_error_flags_ff;
        if (eff_wr && eff_addr == ecw_pkg::OFS_UE_FLAGS) begin
            nxt_flags = nxt_flags & ~(cfg_wdata_i & bmask); // [R24] [R13]
        end
        nxt_flags = (nxt_flags | ev) & ecw_pkg::UE_IMPL;
        if (!surprise_down_capable_i) begin
            nxt_flags[ecw_pkg::UE_SD] = 1'b0; // [R14]
        end
    end

    // sticky: only power-on reset clears, the port reset does not
    always_ff @(posedge mclk_i) begin
        if (!por_n_i) begin
            uncorrectable_error_flags_ff <= ecw_pkg::UE_RESET; // [R12] [R24]
        end else begin
            uncorrectable_error_flags_ff <= nxt_flags; // [R17] [R18]
        end
    end
    assign uncorrectable_error_flags_o = uncorrectable_error_flags_ff;

    // checks
    property p_ptr_rsvd;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (ext_cfg_pointer_ff & ~ecw_pkg::PTR_WMASK) == 32'h0000_0000;
    endproperty
    a_ptr_rsvd: assert property (p_ptr_rsvd) // [R3]
        else $error("pointer reserved bits set");

    property p_win_self;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (cfg_rd_i && win_hit && target == ecw_pkg::OFS_WINDOW)
            |=> cfg_rdata_o == 32'h0000_0000;
    endproperty
    a_win_self: assert property (p_win_self) // [R7]
        else $error("window self read not zero");

    property p_smbus;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (cfg_rd_i && win_hit && cfg_smbus_i)
            |=> cfg_rdata_o == 32'h0000_0000;
    endproperty
    a_smbus: assert property (p_smbus) // [R9]
        else $error("smbus window read not zero");

    property p_win_read;
        @(posedge mclk_i) disable iff (!reset_n_i || !por_n_i)
        (cfg_rd_i && win_ok && target == ecw_pkg::OFS_UE_FLAGS)
            |=> cfg_rdata_o == ($past(uncorrectable_error_flags_ff)
                & $past(bmask));
    endproperty
    a_win_read: assert property (p_win_read) // [R4]
        else $error("window read mismatch");

    property p_hdr;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (cfg_rd_i && !win_hit && cfg_addr_i == ecw_pkg::OFS_CAP_HDR
            && cfg_be_i == 4'hf) |=> cfg_rdata_o[19:0] == 20'h10001;
    endproperty
    a_hdr: assert property (p_hdr) // [R10]
        else $error("header id or version wrong");

    property p_lock;
        @(posedge mclk_i) disable iff (!reset_n_i)
        nxt_ptr_lock_i |=> $stable(next_capability_pointer_ff);
    endproperty
    a_lock: assert property (p_lock) // [R11]
        else $error("locked next pointer changed");

    property p_zero_bits;
        @(posedge mclk_i) disable iff (!por_n_i)
        uncorrectable_error_flags_o[15:14] == 2'b00
            && uncorrectable_error_flags_o[0] == 1'b0;
    endproperty
    a_zero_bits: assert property (p_zero_bits) // [R17]
        else $error("hardwired flag bits set");

    property p_set;
        @(posedge mclk_i) disable iff (!por_n_i)
        err_malformed_i |=> uncorrectable_error_flags_o[ecw_pkg::UE_MAL];
    endproperty
    a_set: assert property (p_set) // [R21]
        else $error("malformed flag not set");

    property p_sticky;
        @(posedge mclk_i) disable iff (!por_n_i)
        (uncorrectable_error_flags_o[ecw_pkg::UE_DLP] && !eff_wr)
            |=> uncorrectable_error_flags_o[ecw_pkg::UE_DLP];
    endproperty
    a_sticky: assert property (p_sticky) // [R24]
        else $error("sticky flag lost");

    property p_sd_gate;
        @(posedge mclk_i) disable iff (!por_n_i)
        !surprise_down_capable_i |=>
            !uncorrectable_error_flags_o[ecw_pkg::UE_SD];
    endproperty
    a_sd_gate: assert property (p_sd_gate) // [R14]
        else $error("surprise down flag without capability");

    // read valid follows every read strobe by exactly one cycle
    property p_rvalid;
        @(posedge mclk_i) disable iff (!reset_n_i)
        cfg_rvalid_o == $past(cfg_rd_i);
    endproperty
    a_rvalid: assert property (p_rvalid) // [R4]
        else $error("read valid not one cycle after read");

    property p_self_ptr;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (cfg_wr_i && win_ok && target == ecw_pkg::OFS_POINTER
            && cfg_be_i[0])
            |=> (ext_cfg_pointer_ff & ecw_pkg::PTR_WMASK & 32'h0000_00ff)
            == ($past(cfg_wdata_i) & ecw_pkg::PTR_WMASK & 32'h0000_00ff);
    endproperty
    a_self_ptr: assert property (p_self_ptr) // [R8]
        else $error("window write missed the pointer");

    property p_win_drop;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (cfg_wr_i && win_hit && target == ecw_pkg::OFS_WINDOW)
            |=> $stable(ext_cfg_pointer_ff)
            && $stable(next_capability_pointer_ff);
    endproperty
    a_win_drop: assert property (p_win_drop) // [R7]
        else $error("window write to itself took effect");

    // an inert write must not touch any register, flags included
    property p_smbus_drop;
        @(posedge mclk_i) disable iff (!reset_n_i || !por_n_i)
        (cfg_wr_i && win_hit && cfg_smbus_i && !(|ev)
            && surprise_down_capable_i)
            |=> $stable(uncorrectable_error_flags_o)
            && $stable(ext_cfg_pointer_ff)
            && $stable(next_capability_pointer_ff);
    endproperty
    a_smbus_drop: assert property (p_smbus_drop) // [R9]
        else $error("smbus window write took effect");

    // ones clear, zeros keep; quiet cycles only, events win otherwise
    property p_w1c;
        @(posedge mclk_i) disable iff (!por_n_i)
        (cfg_wr_i && !win_hit && cfg_addr_i == ecw_pkg::OFS_UE_FLAGS
            && cfg_be_i == 4'hf && !(|ev) && surprise_down_capable_i)
            |=> uncorrectable_error_flags_o
                == ($past(uncorrectable_error_flags_o)
                & ~$past(cfg_wdata_i));
    endproperty
    a_w1c: assert property (p_w1c) // [R24]
        else $error("one-to-clear write wrong");

    property p_set_dlp;
        @(posedge mclk_i) disable iff (!por_n_i)
        err_link_protocol_i
            |=> uncorrectable_error_flags_o[ecw_pkg::UE_DLP];
    endproperty
    a_set_dlp: assert property (p_set_dlp) // [R13]
        else $error("link protocol flag not set");

    property p_set_sd;
        @(posedge mclk_i) disable iff (!por_n_i)
        (err_surprise_down_i && surprise_down_capable_i)
            |=> uncorrectable_error_flags_o[ecw_pkg::UE_SD];
    endproperty
    a_set_sd: assert property (p_set_sd) // [R14]
        else $error("surprise down flag not set");

    property p_set_pois;
        @(posedge mclk_i) disable iff (!por_n_i)
        err_poisoned_i
            |=> uncorrectable_error_flags_o[ecw_pkg::UE_POIS];
    endproperty
    a_set_pois: assert property (p_set_pois) // [R15]
        else $error("poisoned flag not set");

    property p_set_fcp;
        @(posedge mclk_i) disable iff (!por_n_i)
        err_flow_control_i
            |=> uncorrectable_error_flags_o[ecw_pkg::UE_FCP];
    endproperty
    a_set_fcp: assert property (p_set_fcp) // [R16]
        else $error("flow control flag not set");

    property p_set_uec;
        @(posedge mclk_i) disable iff (!por_n_i)
        err_unexp_cpl_i
            |=> uncorrectable_error_flags_o[ecw_pkg::UE_UEC];
    endproperty
    a_set_uec: assert property (p_set_uec) // [R19]
        else $error("unexpected completion flag not set");

    property p_set_rovr;
        @(posedge mclk_i) disable iff (!por_n_i)
        err_rcv_overflow_i
            |=> uncorrectable_error_flags_o[ecw_pkg::UE_ROVR];
    endproperty
    a_set_rovr: assert property (p_set_rovr) // [R20]
        else $error("receiver overflow flag not set");

    property p_set_ecrc;
        @(posedge mclk_i) disable iff (!por_n_i)
        err_ecrc_i
            |=> uncorrectable_error_flags_o[ecw_pkg::UE_ECRC];
    endproperty
    a_set_ecrc: assert property (p_set_ecrc) // [R22]
        else $error("end-to-end crc flag not set");

    property p_set_ur;
        @(posedge mclk_i) disable iff (!por_n_i)
        err_unsup_req_i
            |=> uncorrectable_error_flags_o[ecw_pkg::UE_UR];
    endproperty
    a_set_ur: assert property (p_set_ur) // [R23]
        else $error("unsupported request flag not set");

    // main scenarios a run should reach
    c_win_rd: cover property (@(posedge mclk_i) cfg_rd_i && win_ok);
    c_win_ptr: cover property (@(posedge mclk_i)
        eff_wr && win_hit && target == ecw_pkg::OFS_POINTER);
    c_w1c: cover property (@(posedge mclk_i)
        eff_wr && eff_addr == ecw_pkg::OFS_UE_FLAGS && |ev);
    c_rd_wr: cover property (@(posedge mclk_i) cfg_rd_i && cfg_wr_i);
    c_sd_masked: cover property (@(posedge mclk_i)
        err_surprise_down_i && !surprise_down_capable_i);
endmodule

// >>> verification/ecw_host.sv
// Purpose: config host model making single accesses
// Assumes: one-cycle strobe, answer one cycle after it
// Notes: idle data bus shows inverted data, never stale
`timescale 1ns/1ps
module ecw_host (
    input wire logic mclk_i,
    output logic cfg_wr_o,
    output logic cfg_rd_o,
    output logic cfg_smbus_o,
    output logic [11:0] cfg_addr_o,
    output logic [3:0] cfg_be_o,
    output logic [31:0] cfg_wdata_o,
    input wire logic [31:0] cfg_rdata_i
);
    // bus idle at time zero
    initial begin
        cfg_wr_o = 1'b0;
        cfg_rd_o = 1'b0;
        cfg_smbus_o = 1'b0;
        cfg_addr_o = 12'h000;
        cfg_be_o = 4'h0;
        cfg_wdata_o = 32'h0;
    end
    // gap lets the host be slow as well as prompt
    task automatic access(input logic wr, input logic rd,
        input logic smb, input logic [11:0] a, input logic [3:0] be,
        input logic [31:0] wd, input int gap, output logic [31:0] q);
        repeat (gap + 1) @(posedge mclk_i);
        cfg_wr_o <= wr;
        cfg_rd_o <= rd;
        cfg_smbus_o <= smb;
        cfg_addr_o <= a;
        cfg_be_o <= be;
        cfg_wdata_o <= wd;
        @(posedge mclk_i);
        cfg_wr_o <= 1'b0;
        cfg_rd_o <= 1'b0;
        cfg_wdata_o <= ~wd;
        @(posedge mclk_i);
        q = cfg_rdata_i;
    endtask
endmodule

// >>> verification/ecw_regs_tb.sv
// Purpose: self-checking bench for the config window and flags
// Assumes: host model drives cfg bus, bench drives events
// Notes: flag model runs with capability high; fixed expected values keep bit 5 clear while it is low
`timescale 1ns/1ps
module ecw_regs_tb;
    logic mclk_i = 1'b0;
    logic reset_n_i, por_n_i, lock, sdc, wr, rd, smb, rv;
    logic [8:0] ev;
    logic [3:0] be;
    logic [11:0] addr;
    logic [31:0] wd, rdata, fl_o, m_fl, v, w, seed;
    logic [11:0] tgt;
    int err_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    ecw_host ecw_host_inst (.mclk_i(mclk_i), .cfg_wr_o(wr),
        .cfg_rd_o(rd), .cfg_smbus_o(smb), .cfg_addr_o(addr),
        .cfg_be_o(be), .cfg_wdata_o(wd), .cfg_rdata_i(rdata));
    ecw_regs ecw_regs_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .por_n_i(por_n_i), .cfg_wr_i(wr), .cfg_rd_i(rd),
        .cfg_smbus_i(smb), .cfg_addr_i(addr), .cfg_be_i(be),
        .cfg_wdata_i(wd), .cfg_rdata_o(rdata), .cfg_rvalid_o(rv),
        .nxt_ptr_lock_i(lock), .surprise_down_capable_i(sdc),
        .err_link_protocol_i(ev[0]), .err_surprise_down_i(ev[1]),
        .err_poisoned_i(ev[2]), .err_flow_control_i(ev[3]),
        .err_unexp_cpl_i(ev[4]), .err_rcv_overflow_i(ev[5]),
        .err_malformed_i(ev[6]), .err_ecrc_i(ev[7]),
        .err_unsup_req_i(ev[8]), .uncorrectable_error_flags_o(fl_o),
        .window_target_o(tgt));
    // 25 MHz clock
    always #20 mclk_i = ~mclk_i;
    // hang guard, far above the expected run length
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 6000) begin
            err_count++;
            end_of_test();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // event vector to flag positions
    function automatic logic [31:0] spread(input logic [8:0] e);
        return {11'h0, e[8:4], 2'h0, e[3:2], 6'h0, e[1:0], 4'h0};
    endfunction
    function automatic logic [31:0] bm(input logic [3:0] b);
        return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one host access; reads are compared with exp
    task automatic acc(input logic w_, input logic r_, input logic s_,
        input logic [11:0] a, input logic [3:0] b,
        input logic [31:0] d, input logic [31:0] exp);
        logic [31:0] q;
        ecw_host_inst.access(w_, r_, s_, a, b, d, int'(rnd() & 3), q);
        if (r_) chk(q, exp);
        chk({31'h0, rv}, {31'h0, r_});
    endtask
    task automatic pulse(input logic [8:0] e);
        @(posedge mclk_i);
        ev <= e;
        @(posedge mclk_i);
        ev <= 9'h0;
    endtask
    task automatic end_of_test();
        $display("compares=%0d mismatches=%0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        reset_n_i = 1'b0;
        por_n_i = 1'b0;
        lock = 1'b0;
        sdc = 1'b1;
        ev = 9'h0;
        seed = 32'd28480;
        m_fl = 32'h0;
        repeat (10) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        por_n_i <= 1'b1;
        acc(0, 1, 0, 12'h0f8, 4'hf, 0, 32'h0);
        acc(0, 1, 0, 12'h100, 4'hf, 0, 32'h2001_0001);
        acc(0, 1, 0, 12'h200, 4'hf, 0, 32'h0);
        acc(1, 0, 0, 12'h0f8, 4'hf, 32'hffff_ffff, 0);
        acc(0, 1, 0, 12'h0f8, 4'hf, 0, 32'h0000_0ffc);
        chk({20'h0, tgt}, 32'h0000_0ffc);
        acc(1, 0, 0, 12'h0f8, 4'hf, 32'h0fc, 0);
        acc(0, 1, 0, 12'h0fc, 4'hf, 0, 32'h0);
        acc(1, 0, 0, 12'h0fc, 4'hf, 32'h0f8, 0);
        acc(0, 1, 0, 12'h0f8, 4'hf, 0, 32'h0fc);
        acc(1, 0, 0, 12'h0f8, 4'hf, 32'h0f8, 0);
        acc(1, 0, 0, 12'h0fc, 4'h1, 32'h0000_0104, 0);
        acc(0, 1, 0, 12'h0f8, 4'hf, 0, 32'h004);
        acc(1, 0, 0, 12'h0f8, 4'hf, 32'h104, 0);
        // random events, window reads and one-to-clear writes
        for (int i = 0; i < 24; i++) begin
            v = rnd();
            w = rnd();
            pulse(v[8:0]);
            m_fl |= spread(v[8:0]);
            acc(0, 1, v[13], 12'h0fc, v[12:9], 0,
                v[13] ? 32'h0 : m_fl & bm(v[12:9]));
            acc(1, 0, v[13], 12'h0fc, v[12:9], w, 0);
            if (!v[13]) m_fl &= ~(w & bm(v[12:9]) & ecw_pkg::UE_IMPL);
            chk(fl_o, m_fl);
        end
        acc(1, 0, 0, 12'h104, 4'hf, 32'hffff_ffff, 0);
        pulse(9'h1ff);
        acc(0, 1, 0, 12'h104, 4'hf, 0, 32'h001f_3030);
        acc(1, 0, 0, 12'h104, 4'hf, 32'hffff_ffff, 0);
        sdc <= 1'b0;
        pulse(9'h1ff);
        acc(0, 1, 0, 12'h104, 4'hf, 0, 32'h001f_3010);
        // port reset keeps flags, restores pointer
        reset_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        acc(0, 1, 0, 12'h104, 4'hf, 0, 32'h001f_3010);
        // event and one-to-clear in the same cycle: the event wins
        fork
            ecw_host_inst.access(1, 0, 0, 12'h104, 4'hf, 32'hffff_ffff,
                0, v);
            pulse(9'h040);
        join
        chk(fl_o, 32'h0004_0000);
        // read and write together: the read sees the old flags
        acc(1, 1, 0, 12'h104, 4'hf, 32'hffff_ffff, 32'h0004_0000);
        chk(fl_o, 32'h0);
        acc(0, 1, 0, 12'h0f8, 4'hf, 0, 32'h0);
        lock <= 1'b1;
        acc(1, 0, 0, 12'h100, 4'hf, 32'hffff_ffff, 0);
        acc(0, 1, 0, 12'h100, 4'hf, 0, 32'h2001_0001);
        lock <= 1'b0;
        acc(1, 0, 0, 12'h100, 4'hf, 32'hffff_ffff, 0);
        acc(0, 1, 0, 12'h100, 4'hf, 0, 32'hfff1_0001);
        por_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        por_n_i <= 1'b1;
        @(posedge mclk_i);
        chk(fl_o, 32'h0);
        end_of_test();
    end
endmodule
